// file: inc/sfp_pkg.sv
package sfp_pkg;
    // opcodes
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_PROG      = 8'h02;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_STAT_RD   = 8'h05;
    localparam logic [7:0] OP_STAT_PROG = 8'h01;
    // frame clock counts
    localparam logic [7:0] CNT_LATCH    = 8'h08;
    localparam logic [7:0] CNT_STATUS   = 8'h10;
    localparam logic [7:0] CNT_SECTOR   = 8'h98;
    localparam logic [7:0] CNT_MAX      = 8'hff;
    // array geometry
    localparam int         MEM_DEPTH    = 1024;
    localparam int         PAGE_N       = 16;
    localparam logic [9:0] ADDR_LAST    = 10'h3ff;
    localparam logic [2:0] LOCK_RESET   = 3'h0;
    // self-timed program cycle
    localparam int unsigned CLK_HZ       = 25000000;
    localparam int unsigned PROG_TIME_MS = 5;
    localparam int unsigned PROG_CYC_DEF = PROG_TIME_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {PH_CMD, PH_ADDH, PH_ADDL, PH_DATA, PH_IDLE} sfp_phase_t;
    typedef enum logic {NV_SECTOR, NV_STATUS} sfp_kind_t;
    typedef logic [15:0][7:0] sfp_page_t;

    // link-side frame state, held after select rises until next frame
    typedef struct packed {
        sfp_phase_t phase;
        logic [2:0] bitc;
        logic [7:0] cnt;
        logic [7:0] shreg;
        logic [7:0] cmd;
        logic [9:0] addr;
        logic [3:0] dcnt;
        sfp_page_t  page;
        logic [7:0] stat_new;
    } sfp_link_t;

    typedef struct packed {
        logic cs_prev;
        logic armed;
        logic frame_ok;
        logic wp_drop;
        logic wel;
    } sfp_core_t;

    typedef struct packed {
        logic       start;
        sfp_kind_t  kind;
        logic [9:0] base;
        sfp_page_t  page;
        logic [2:0] lock;
    } sfp_req_t;

    typedef struct packed {
        logic       busy;
        sfp_kind_t  kind;
        logic [16:0] cnt;
        logic [9:0] base;
        sfp_page_t  page;
        logic [2:0] lock_new;
        logic [2:0] lock;
    } sfp_nvm_t;

    localparam sfp_link_t LINK_RESET = '0;
    localparam sfp_core_t CORE_RESET = '0;
    localparam sfp_nvm_t  NVM_RESET  = '{busy: 1'b0, kind: NV_SECTOR, cnt: '0, base: '0,
                                         page: '0, lock_new: LOCK_RESET, lock: LOCK_RESET};

    // protected-sector decode of the eight lock settings
    function automatic logic sfp_prot(input logic [2:0] lock, input logic [5:0] sect);
        case (lock)
            3'h0:                   sfp_prot = 1'b0;
            3'h1, 3'h2, 3'h3, 3'h4: sfp_prot = (sect[5:4] == 2'(lock - 3'h1));
            3'h5:                   sfp_prot = !sect[5];
            3'h6:                   sfp_prot = (sect == 6'h00);
            default:                sfp_prot = (sect == 6'h3f);
        endcase
    endfunction
endpackage

// file: rtl/sfp_sync.sv
`timescale 1ns/100ps
module sfp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    // levels
    input  wire logic [W-1:0] d_in,
    output logic [W-1:0]      q_out
);
    logic [W-1:0] meta_q;

    // two flops; only the second stage is visible outside
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // sfp_sync

// file: rtl/sfp_nvm.sv
`timescale 1ns/100ps
module sfp_nvm import sfp_pkg::*; #(
    parameter int unsigned PROG_CYCLES = PROG_CYC_DEF
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    // write request and read port
    input  wire sfp_req_t   req_in,
    input  wire logic [9:0] rd_addr_in,
    output logic [7:0]      rd_data_out,
    // state
    output logic            busy_out,
    output logic            sect_done_out,
    output logic [2:0]      lock_out
);
    sfp_nvm_t   nv_q;
    sfp_nvm_t   nv_d;
    logic       fin;
    logic [7:0] mem_q [MEM_DEPTH];

    assign fin = nv_q.busy && (nv_q.cnt == 17'(PROG_CYCLES - 1));

    // self-timed cycle; the request is copied so the link may start a new frame
    always_comb begin
        nv_d = nv_q;
        if (nv_q.busy) begin
            nv_d.cnt = nv_q.cnt + 17'h00001;
        end
        if (fin) begin
            nv_d.busy = 1'b0;
            if (nv_q.kind == NV_STATUS) begin
                nv_d.lock = nv_q.lock_new;
            end
        end
        if (req_in.start && !nv_q.busy) begin
            nv_d.busy     = 1'b1;
            nv_d.cnt      = '0;
            nv_d.kind     = req_in.kind;
            nv_d.base     = req_in.base;
            nv_d.page     = req_in.page;
            nv_d.lock_new = req_in.lock;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            nv_q <= NVM_RESET;
        end else begin
            nv_q <= nv_d;
        end
    end

    // array cells commit at the end of the cycle, not at its start
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < PAGE_N; i++) begin
            if (fin && nv_q.kind == NV_SECTOR) begin
                mem_q[{nv_q.base[9:4], 4'(i)}] <= nv_q.page[i];
            end
        end
    end

    assign rd_data_out   = mem_q[rd_addr_in];
    assign busy_out      = nv_q.busy;
    assign sect_done_out = fin && (nv_q.kind == NV_SECTOR);
    assign lock_out      = nv_q.lock;
endmodule // sfp_nvm

// file: rtl/sfp_top.sv
`timescale 1ns/100ps
module sfp_top import sfp_pkg::*; #(
    parameter int unsigned PROG_CYCLES = PROG_CYC_DEF
) (
    // system clock and reset
    input  wire logic  clk_in,
    input  wire logic  rst_b_in,
    // serial link pins
    input  wire logic  sck_in,
    input  wire logic  chip_sel_b_in,
    input  wire logic  si_in,
    input  wire logic  write_protect_n_in,
    output logic       so_out,
    output logic       so_oe_b_out,
    // device state
    output logic       standby_out,
    output logic       write_busy_out,
    output logic       write_latch_out,
    output logic [2:0] lock_select_out
);

////////////////////////////////////////////////////////////////////////////////
// declarations

    sfp_link_t  lk_q;
    sfp_link_t  lk_d;
    logic       fresh_q;
    logic       so_q;
    logic       so_d;
    logic [7:0] byte_v;
    logic [3:0] pidx;
    sfp_core_t  core_q;
    sfp_core_t  core_d;
    logic [1:0] pin_s;
    logic       cs_s;
    logic       wp_s;
    logic       cs_rise;
    logic       cs_fall;
    logic       frame_end;
    logic       ev_set;
    logic       prot_hit;
    logic       busy_s;
    logic       nv_busy;
    logic       nv_done;
    logic [2:0] lock;
    logic [7:0] rd_data;
    logic [7:0] stat_byte;
    sfp_req_t   req;
    int unsigned busy_len_q;

////////////////////////////////////////////////////////////////////////////////
// crossings

    // select and protect pins into the system clock
    sfp_sync #(.W(2)) u_pin_sync (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .d_in     ({chip_sel_b_in, write_protect_n_in}),
        .q_out    (pin_s)
    );

    assign cs_s = pin_s[1];
    assign wp_s = pin_s[0];

    // busy into the link domain; it only moves while the master clocks
    sfp_sync #(.W(1)) u_busy_sync (
        .clk_in   (sck_in),
        .rst_b_in (rst_b_in),
        .d_in     (nv_busy),
        .q_out    (busy_s)
    );

////////////////////////////////////////////////////////////////////////////////
// link domain: frame start marker

    // preset while deselected, so the first rising edge restarts the frame;
    // frame fields stay put after select rises for the core to read
    always_ff @(posedge sck_in or posedge chip_sel_b_in or negedge rst_b_in) begin
        if (chip_sel_b_in || !rst_b_in) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// link domain: input shifter and decode on rising edges

    always_comb begin
        lk_d = lk_q;
        if (fresh_q) begin
            lk_d.phase = PH_CMD;
            lk_d.bitc  = '0;
            lk_d.cnt   = '0;
            lk_d.dcnt  = '0;
        end
        byte_v     = {lk_d.shreg[6:0], si_in};
        lk_d.shreg = byte_v;
        pidx       = 4'(lk_d.addr[3:0] + lk_d.dcnt);
        if (lk_d.cnt != CNT_MAX) begin
            lk_d.cnt = lk_d.cnt + 8'h01;
        end
        if (lk_d.bitc == 3'h7) begin
            case (lk_d.phase)
                PH_CMD: begin
                    lk_d.cmd = byte_v;
                    case (byte_v)
                        OP_READ, OP_PROG:        lk_d.phase = PH_ADDH;
                        OP_STAT_RD, OP_STAT_PROG: lk_d.phase = PH_DATA;
                        default:                 lk_d.phase = PH_IDLE;
                    endcase
                end
                PH_ADDH: begin
                    lk_d.addr[9:8] = byte_v[1:0];
                    lk_d.phase     = PH_ADDL;
                end
                PH_ADDL: begin
                    lk_d.addr[7:0] = byte_v;
                    lk_d.phase     = PH_DATA;
                end
                PH_DATA: begin
                    if (lk_d.cmd == OP_READ) begin
                        lk_d.addr = lk_d.addr + 10'h001;
                    end
                    if (lk_d.cmd == OP_PROG) begin
                        lk_d.page[pidx] = byte_v;
                        lk_d.dcnt       = lk_d.dcnt + 4'h1;
                    end
                    if (lk_d.cmd == OP_STAT_PROG) begin
                        lk_d.stat_new = byte_v;
                    end
                end
                default: begin
                end
            endcase
        end
        lk_d.bitc = lk_d.bitc + 3'h1;
    end

    always_ff @(posedge sck_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lk_q <= LINK_RESET;
        end else begin
            lk_q <= lk_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// link domain: serial output on falling edges

    assign stat_byte = {5'h00, lock};

    // bit pointer is the count of bits already taken in this byte
    always_comb begin
        so_d = 1'b0;
        if (!fresh_q && lk_q.phase == PH_DATA) begin
            if (lk_q.cmd == OP_READ) begin
                so_d = busy_s ? 1'b1 : rd_data[~lk_q.bitc];
            end else if (lk_q.cmd == OP_STAT_RD) begin
                so_d = busy_s ? 1'b1 : stat_byte[~lk_q.bitc];
            end
        end
    end

    always_ff @(negedge sck_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            so_q <= 1'b0;
        end else begin
            so_q <= so_d;
        end
    end

    // float whenever deselected or before the first qualified frame
    assign so_out      = so_q;
    assign so_oe_b_out = chip_sel_b_in || !core_q.frame_ok;

////////////////////////////////////////////////////////////////////////////////
// system domain: frame qualification and write latch

    assign cs_rise   = cs_s && !core_q.cs_prev;
    assign cs_fall   = !cs_s && core_q.cs_prev;
    assign frame_end = cs_rise && core_q.frame_ok && !core_q.wp_drop && wp_s;
    assign ev_set    = frame_end && lk_q.cmd == OP_SET_LATCH && lk_q.cnt == CNT_LATCH;
    assign prot_hit  = sfp_prot(lock, {1'b0, lk_q.addr[8:4]});

    // frame fields are quiet here: the last link edge is two flops older
    always_comb begin
        core_d         = core_q;
        core_d.cs_prev = cs_s;
        req            = '{start: 1'b0, kind: NV_SECTOR, base: '0, page: '0, lock: '0};
        req.base       = {1'b0, lk_q.addr[8:4], 4'h0};
        req.page       = lk_q.page;
        req.lock       = lk_q.stat_new[2:0];
        if (cs_s) begin
            core_d.armed = 1'b1;
        end
        if (cs_fall) begin
            core_d.frame_ok = core_q.armed;
            core_d.wp_drop  = 1'b0;
        end
        if (!cs_s && !wp_s) begin
            core_d.wp_drop = 1'b1;
        end
        if (nv_done) begin
            core_d.wel = 1'b0;
        end
        if (frame_end) begin
            case (lk_q.cmd)
                OP_SET_LATCH: begin
                    if (lk_q.cnt == CNT_LATCH) begin
                        core_d.wel = 1'b1;
                    end
                end
                OP_CLR_LATCH: begin
                    if (lk_q.cnt == CNT_LATCH) begin
                        core_d.wel = 1'b0;
                    end
                end
                OP_PROG: begin
                    if (lk_q.cnt == CNT_SECTOR && core_q.wel && !nv_busy && !prot_hit) begin
                        req.start = 1'b1;
                        req.kind  = NV_SECTOR;
                    end
                end
                OP_STAT_PROG: begin
                    if (lk_q.cnt == CNT_STATUS && core_q.wel && !nv_busy) begin
                        req.start = 1'b1;
                        req.kind  = NV_STATUS;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_q <= CORE_RESET;
        end else begin
            core_q <= core_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// nonvolatile array, status and program timer

    sfp_nvm #(.PROG_CYCLES(PROG_CYCLES)) u_nvm (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .req_in        (req),
        .rd_addr_in    (lk_q.addr),
        .rd_data_out   (rd_data),
        .busy_out      (nv_busy),
        .sect_done_out (nv_done),
        .lock_out      (lock)
    );

    // standby needs select high and no self-timed cycle running
    assign standby_out     = cs_s && !nv_busy;
    assign write_busy_out  = nv_busy;
    assign write_latch_out = core_q.wel;
    assign lock_select_out = lock;

////////////////////////////////////////////////////////////////////////////////
// checks

    // helper: length of the last busy run
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_len_q <= 0;
        end else if (nv_busy) begin
            busy_len_q <= busy_len_q + 1;
        end else if (!$fell(nv_busy)) begin
            busy_len_q <= 0;
        end
    end

    sequence s_frame_end;
        frame_end;
    endsequence

    sequence s_latch_frame;
        s_frame_end ##0 (lk_q.cmd == OP_SET_LATCH && lk_q.cnt == CNT_LATCH);
    endsequence

    sequence s_stat_frame;
        s_frame_end ##0 (lk_q.cmd == OP_STAT_PROG && lk_q.cnt == CNT_STATUS
                         && core_q.wel && !nv_busy);
    endsequence

    chk_latch_set: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) s_latch_frame |=> core_q.wel)
        else $error("write latch not set by set-latch frame");

    chk_stat_start: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) s_stat_frame |-> req.start ##1 nv_busy)
        else $error("status program did not start");

    chk_wp_refuse: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) !wp_s |-> !req.start)
        else $error("write started with protect low");

    chk_wp_abort: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) core_q.wp_drop |-> !req.start)
        else $error("write started after protect dropped in frame");

    chk_power_arm: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) !core_q.frame_ok |-> !req.start)
        else $error("write started before select transition");

    chk_busy_reject: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) nv_busy |-> !req.start)
        else $error("write started while busy");

    chk_sector_len: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (req.start && req.kind == NV_SECTOR) |-> lk_q.cnt == CNT_SECTOR && core_q.wel)
        else $error("sector write with wrong clock count or latch clear");

    chk_prot_reject: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (req.start && req.kind == NV_SECTOR) |-> !prot_hit)
        else $error("write started into protected sector");

    chk_latch_clear: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) (nv_done && !ev_set) |=> !core_q.wel)
        else $error("write latch kept after sector cycle");

    chk_cycle_len: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) $fell(nv_busy) |-> busy_len_q == PROG_CYCLES)
        else $error("program cycle length wrong");

    chk_addr_wrap: assert property (
        @(posedge sck_in) disable iff (!rst_b_in)
        (!fresh_q && lk_q.phase == PH_DATA && lk_q.cmd == OP_READ && lk_q.bitc == 3'h7
         && lk_q.addr == ADDR_LAST) |=> lk_q.addr == 10'h000)
        else $error("read address did not wrap");

    chk_first_edge: assert property (
        @(posedge sck_in) disable iff (!rst_b_in) fresh_q |=> lk_q.cnt == 8'h01)
        else $error("frame did not restart on first edge");

    chk_status_ptr: assert property (
        @(posedge sck_in) disable iff (!rst_b_in)
        (!fresh_q && lk_q.phase == PH_DATA && lk_q.cmd == OP_STAT_RD)
        |=> lk_q.bitc == 3'($past(lk_q.bitc) + 3'h1))
        else $error("status pointer did not advance");

    chk_status_busy: assert property (
        @(negedge sck_in) disable iff (!rst_b_in)
        (!fresh_q && lk_q.phase == PH_DATA && lk_q.cmd == OP_STAT_RD && busy_s) |=> so_q)
        else $error("status read while busy not high");

    chk_cmd_msb: assert property (
        @(posedge sck_in) disable iff (!rst_b_in)
        (!fresh_q && lk_q.phase == PH_CMD && lk_q.bitc == 3'h7)
        |=> lk_q.cmd == {$past(lk_q.shreg[6:0]), $past(si_in)})
        else $error("opcode not assembled msb first");

endmodule // sfp_top

// file: tb/sfp_master.sv
`timescale 1ns/100ps
module sfp_master (
    // serial link pins seen from the master
    output logic      sck_out,
    output logic      cs_b_out,
    output logic      si_out,
    input  wire logic so_in,
    input  wire logic so_oe_b_in
);
    logic so_last;
    logic so_line;
    ////////////////////////////////////////////////////////////////
    // a released line shows the inverse of its last driven level
    always @(so_in or so_oe_b_in) begin
        if (!so_oe_b_in) so_last = so_in;
    end
    assign so_line = so_oe_b_in ? ~so_last : so_in;
    // select idles high so the first frame is a high-to-low edge
    initial begin
        sck_out  = 1'b0;
        cs_b_out = 1'b1;
        si_out   = 1'b0;
        so_last  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // one frame, mode 0; clock stands still between frames
    task automatic frame(input int n, input logic [151:0] tx, output logic [151:0] rx);
        rx = '0;
        cs_b_out = 1'b0;
        #37;
        for (int i = n - 1; i >= 0; i--) begin
            si_out = tx[i];
            #40 sck_out = 1'b1;
            rx[i] = so_line;
            #40 sck_out = 1'b0;
        end
        #100 cs_b_out = 1'b1;
        si_out = ~si_out;
        #300;
    endtask
endmodule // sfp_master

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import sfp_pkg::*;
    logic         clk_in;
    logic         rst_b_in;
    logic         wp_n;
    logic         sck;
    logic         cs_b;
    logic         si;
    logic         so;
    logic         so_oe_b;
    logic         stby;
    logic         busy;
    logic         latch;
    logic [2:0]   lock;
    logic [151:0] rx;
    int           bad_count = 0;
    int           checks_done = 0;
    int           cyc = 0;
    // write cycle keeps busy up across the first status byte of a long frame
    sfp_top #(.PROG_CYCLES(100)) uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .sck_in(sck),
        .chip_sel_b_in(cs_b), .si_in(si), .write_protect_n_in(wp_n), .so_out(so),
        .so_oe_b_out(so_oe_b), .standby_out(stby), .write_busy_out(busy),
        .write_latch_out(latch), .lock_select_out(lock));
    sfp_master mst (.sck_out(sck), .cs_b_out(cs_b), .si_out(si), .so_in(so),
        .so_oe_b_in(so_oe_b));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input int n);
        mst.frame(n, 152'(op) << (n - 8), rx);
        repeat (6) @(negedge clk_in);
    endtask
    // waits for a write to start, then for it to end
    task automatic wait_write(input logic exp);
        for (int k = 0; k < 30 && busy !== 1'b1; k++) @(negedge clk_in);
        chk(8'(busy), 8'(exp), "write start");
        for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clk_in);
    endtask
    task automatic prog(input logic [9:0] a, input logic [7:0] b, input int n);
        logic [151:0] tx;
        tx = {OP_PROG, 6'h0, a, 128'h0};
        for (int i = 0; i < 16; i++) tx[127 - 8 * i -: 8] = b + 8'(i);
        mst.frame(n, tx >> (152 - n), rx);
    endtask
    task automatic rd2(input logic [9:0] a, input logic [7:0] e0, input logic [7:0] e1);
        mst.frame(40, 152'({OP_READ, 6'h0, a, 16'h0}), rx);
        chk(rx[15:8], e0, "read byte 0");
        chk(rx[7:0], e1, "read byte 1");
    endtask
    task automatic stat_prog(input logic [2:0] l);
        cmd(OP_SET_LATCH, 8);
        mst.frame(16, 152'({OP_STAT_PROG, 5'h0, l}), rx);
        wait_write(1'b1);
        chk(8'(lock), 8'(l), "lock pins");
        cmd(OP_STAT_RD, 16);
        chk(rx[7:0], {5'h0, l}, "status byte");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_latch();
        cmd(OP_SET_LATCH, 8);
        chk(8'(latch), 8'h01, "latch set");
        chk({6'h0, stby, so_oe_b}, 8'h03, "standby and float");
        cmd(OP_CLR_LATCH, 8);
        chk(8'(latch), 8'h00, "latch clear");
        cmd(OP_SET_LATCH, 16);
        chk(8'(latch), 8'h00, "long set frame");
        $display("t_latch done");
    endtask
    task automatic t_sector();
        cmd(OP_SET_LATCH, 8);
        prog(10'h1f0, 8'ha0, 152);
        wait_write(1'b1);
        chk(8'(latch), 8'h00, "latch after write");
        cmd(OP_SET_LATCH, 8);
        prog(10'h000, 8'h50, 152);
        // pointer keeps turning while busy, so the last byte lines up
        mst.frame(72, 152'(OP_STAT_RD) << 64, rx);
        chk(rx[63:56], 8'hff, "busy status");
        chk(rx[7:0], 8'h00, "status after busy");
        // the write ended inside the status frame and cleared the latch
        chk({6'h0, busy, latch}, 8'h00, "write over");
        rd2(10'h1fe, 8'hae, 8'haf);
        // the top cell is never programmed; only the byte after the wrap is known
        mst.frame(40, 152'({OP_READ, 6'h0, 10'h3ff, 16'h0}), rx);
        chk(rx[7:0], 8'h50, "read wrap");
        $display("t_sector done");
    endtask
    task automatic t_protect();
        stat_prog(3'h6);
        cmd(OP_SET_LATCH, 8);
        prog(10'h000, 8'h11, 152);
        wait_write(1'b0);
        chk(8'(latch), 8'h01, "latch kept");
        @(negedge clk_in) wp_n = 1'b0;
        prog(10'h1f0, 8'h77, 152);
        wait_write(1'b0);
        rd2(10'h00e, 8'h5e, 8'h5f);
        @(negedge clk_in) wp_n = 1'b1;
        // protect dips mid-frame and recovers before select rises
        fork
            prog(10'h1f0, 8'h77, 152);
            begin
                repeat (100) @(negedge clk_in);
                wp_n = 1'b0;
                repeat (4) @(negedge clk_in);
                wp_n = 1'b1;
            end
        join
        wait_write(1'b0);
        prog(10'h1f0, 8'h77, 151);
        wait_write(1'b0);
        rd2(10'h1fe, 8'hae, 8'haf);
        stat_prog(3'h0);
        $display("t_protect done");
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d, wrong %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // a hang is cut short well after the expected run length
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        rst_b_in = 1'b0;
        wp_n = 1'b1;
        repeat (8) @(negedge clk_in);
        rst_b_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_latch();
        t_sector();
        t_protect();
        conclude();
    end
endmodule // tb_top
